// ---- rtl/swdbg_core.sv ----
// Single-wire debug command decoder: bit engine, sync response and command sequencer
`timescale 1ns/1ps

module swdbg_core (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Debug wire pin
    input wire logic DBG_WIRE_I,
    output logic DBG_WIRE_O,
    output logic DBG_WIRE_OE_N,
    // CPU state and execution control
    input wire logic CPU_HALTED,
    input wire swdbg_pkg::swdbg_cpu_t CPU_REGS,
    output swdbg_pkg::swdbg_regwr_t REG_WR,
    output logic HALT_REQ,
    output logic RESUME,
    output logic STEP,
    // Memory access, read data sampled in the same cycle as the request
    input wire logic [7:0] MEM_RDATA,
    output swdbg_pkg::swdbg_mem_t MEM,
    // Debug configuration
    output logic [7:0] STATUS_CTL,
    output logic [15:0] BKPT_MATCH,
    output logic ACK_EN
);
    import swdbg_pkg::*;

    swdbg_ln_t ln_r, ln_nxt;
    swdbg_ph_t ph_r, ph_nxt;
    swdbg_fmt_t fmt_r, fmt_nxt;
    swdbg_mem_t mem_r, mem_nxt;
    swdbg_regwr_t rw_r, rw_nxt;
    logic [8:0] cyc_r, cyc_nxt;
    logic [9:0] tmo_r, tmo_nxt;
    logic [4:0] nb_r, nb_nxt;
    logic [4:0] dc_r, dc_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [15:0] adr_r, adr_nxt;
    logic [15:0] last_r, last_nxt;
    logic [15:0] bkpt_r, bkpt_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic [7:0] ctl_r, ctl_nxt;
    logic din_q_r, hlt_q_r, exe_r, exe_nxt, rdv_r, rdv_nxt, ack_r, ack_nxt;
    logic halt_r, halt_nxt, res_r, res_nxt, stp_r, stp_nxt;
    logic o_r, o_nxt, oen_r, oen_nxt;

    // Packed as {ok, halted only, address}, write size, {delay, status}, read size
    function automatic swdbg_fmt_t swdbg_decode(input logic [7:0] code);
        unique case (code)
            CMD_ACK_ON, CMD_ACK_OFF, CMD_BACKGROUND: return {3'h4, 2'h0, 2'h2, 2'h0};
            CMD_STAT_FETCH: return {3'h4, 2'h0, 2'h0, 2'h1};
            CMD_CTRL_STORE: return {3'h4, 2'h1, 2'h0, 2'h0};
            CMD_MEM_FETCH: return {3'h5, 2'h0, 2'h2, 2'h1};
            CMD_MEM_FETCH_FLAGS: return {3'h5, 2'h0, 2'h3, 2'h1};
            CMD_LAST_FETCH_FLAGS: return {3'h4, 2'h0, 2'h1, 2'h1};
            CMD_MEM_STORE: return {3'h5, 2'h1, 2'h2, 2'h0};
            CMD_MEM_STORE_FLAGS: return {3'h5, 2'h1, 2'h3, 2'h0};
            CMD_MATCH_FETCH: return {3'h4, 2'h0, 2'h0, 2'h2};
            CMD_MATCH_STORE: return {3'h4, 2'h2, 2'h0, 2'h0};
            CMD_RESUME, CMD_SINGLE_STEP, CMD_RESUME_TAGGED: return {3'h6, 2'h0, 2'h2, 2'h0};
            CMD_ACC_FETCH, CMD_FLAGS_FETCH, CMD_INDEX_STEP_FETCH: return {3'h6, 2'h0, 2'h2, 2'h1};
            CMD_INDEX_STEP_FETCH_FLAGS: return {3'h6, 2'h0, 2'h3, 2'h1};
            CMD_PC_FETCH, CMD_INDEX_FETCH, CMD_STACK_PTR_FETCH: return {3'h6, 2'h0, 2'h2, 2'h2};
            CMD_ACC_STORE, CMD_FLAGS_STORE, CMD_INDEX_STEP_STORE: return {3'h6, 2'h1, 2'h2, 2'h0};
            CMD_INDEX_STEP_STORE_FLAGS: return {3'h6, 2'h1, 2'h3, 2'h0};
            CMD_PC_STORE, CMD_INDEX_STORE, CMD_STACK_PTR_STORE: return {3'h6, 2'h2, 2'h2, 2'h0};
            default: return '0;
        endcase
    endfunction : swdbg_decode

    // Phases run in the fixed order code, address, write, delay, status, read
    function automatic swdbg_ph_t swdbg_next(input swdbg_fmt_t f, input swdbg_ph_t ph);
        swdbg_ph_t n;
        n = PH_CMD;
        if (f.rd != 2'h0 && ph != PH_RD) n = PH_RD;
        if (f.ss && ph != PH_SS && ph != PH_RD) n = PH_SS;
        if (f.dly && (ph == PH_CMD || ph == PH_ADR || ph == PH_WD)) n = PH_DLY;
        if (f.wd != 2'h0 && (ph == PH_CMD || ph == PH_ADR)) n = PH_WD;
        if (f.adr && ph == PH_CMD) n = PH_ADR;
        return n;
    endfunction : swdbg_next

    always_comb begin
        swdbg_fmt_t f;
        logic [7:0] c;
        logic [7:0] stat;
        logic [15:0] av;
        logic [15:0] wv;
        logic [15:0] ix1;
        logic e, edge_s, rx, tx, done, fin, abort;
        ln_nxt = ln_r;
        ph_nxt = ph_r;
        fmt_nxt = fmt_r;
        cyc_nxt = cyc_r;
        nb_nxt = nb_r;
        dc_nxt = dc_r;
        sh_nxt = sh_r;
        adr_nxt = adr_r;
        last_nxt = last_r;
        bkpt_nxt = bkpt_r;
        cmd_nxt = cmd_r;
        ctl_nxt = ctl_r;
        exe_nxt = exe_r;
        ack_nxt = ack_r;
        mem_nxt = mem_r;
        mem_nxt.req = 1'b0;
        rw_nxt = rw_r;
        rw_nxt.we = 1'b0;
        halt_nxt = 1'b0;
        res_nxt = 1'b0;
        stp_nxt = 1'b0;
        rdv_nxt = 1'b0;
        rd_nxt = rdv_r ? MEM_RDATA : rd_r;
        o_nxt = 1'b1;
        oen_nxt = 1'b1;
        done = 1'b0;
        fin = 1'b0;
        abort = 1'b0;
        f = (ph_r == PH_CMD) ? swdbg_decode(sh_r[7:0]) : fmt_r;
        c = (ph_r == PH_CMD) ? sh_r[7:0] : cmd_r;
        e = ((ph_r == PH_CMD) ? f.ok : exe_r) && (!f.abm || CPU_HALTED);
        stat = {ctl_r[PERMIT_BIT], CPU_HALTED, ctl_r[5:0]};
        av = (ph_r == PH_ADR) ? sh_r : adr_r;
        wv = (ph_r == PH_WD) ? sh_r : adr_r;
        ix1 = CPU_REGS.ix + 16'h0001;
        rx = (ph_r == PH_CMD) || (ph_r == PH_ADR) || (ph_r == PH_WD);
        tx = (ph_r == PH_SS) || (ph_r == PH_RD);
        edge_s = din_q_r && !DBG_WIRE_I;
        tmo_nxt = (tmo_r == TMO_CYC) ? tmo_r : tmo_r + 10'h001;

        unique case (ln_r)
            LN_WAIT: begin
                if (edge_s) begin
                    ln_nxt = LN_BIT;
                    cyc_nxt = 9'h001;
                    tmo_nxt = 10'h000;
                end else if (tmo_r == TMO_CYC - 10'h001 && (ph_r != PH_CMD || nb_r != BYTE_BITS)) begin
                    abort = 1'b1;
                end
            end
            LN_BIT: begin
                cyc_nxt = cyc_r + 9'h001;
                if (rx && cyc_r == RX_SAMPLE_CYC) begin
                    sh_nxt = {sh_r[14:0], DBG_WIRE_I};
                end
                if (!DBG_WIRE_I && cyc_r == SYNC_DET_CYC) begin
                    ln_nxt = LN_SYNC_HI;
                    abort = 1'b1;
                end else if (DBG_WIRE_I && cyc_r >= BIT_MIN_CYC) begin
                    ln_nxt = LN_WAIT;
                    done = 1'b1;
                end
            end
            LN_SYNC_HI: begin
                if (DBG_WIRE_I) begin
                    ln_nxt = LN_SYNC_DLY;
                    cyc_nxt = 9'h000;
                end
            end
            LN_SYNC_DLY: begin
                cyc_nxt = cyc_r + 9'h001;
                if (cyc_r == SYNC_WAIT_CYC - 9'h001) begin
                    ln_nxt = LN_SYNC_LO;
                    cyc_nxt = 9'h000;
                end
            end
            LN_SYNC_LO: begin
                cyc_nxt = cyc_r + 9'h001;
                if (cyc_r == SYNC_LOW_CYC - 9'h001) begin
                    ln_nxt = LN_SYNC_PU;
                end
            end
            LN_SYNC_PU: ln_nxt = LN_WAIT;
        endcase

        if (done && ph_r != PH_DLY) begin
            if (tx) begin
                sh_nxt = {sh_r[14:0], 1'b0};
            end
            nb_nxt = nb_r - 5'h01;
            fin = (nb_r == 5'h01);
        end
        if (ph_r == PH_DLY) begin
            dc_nxt = dc_r + 5'h01;
            fin = (dc_r == DLY_CYC - 5'h01);
        end

        if (fin) begin
            unique case (ph_r)
                PH_CMD: begin
                    fmt_nxt = f;
                    cmd_nxt = c;
                    exe_nxt = e;
                    if (e && c == CMD_LAST_FETCH_FLAGS) begin
                        mem_nxt = '{req: 1'b1, we: 1'b0, addr: last_r, wdata: mem_r.wdata};
                        rdv_nxt = 1'b1;
                    end
                end
                PH_ADR: adr_nxt = sh_r;
                PH_WD: begin
                    adr_nxt = av;
                    if (c == CMD_CTRL_STORE) begin
                        ctl_nxt = (sh_r[7:0] & (CPU_HALTED ? CTL_HALT_MASK : CTL_WR_MASK))
                            | (ctl_r & ~(CPU_HALTED ? CTL_HALT_MASK : CTL_WR_MASK));
                    end
                    if (c == CMD_MATCH_STORE) begin
                        bkpt_nxt = sh_r;
                    end
                end
                default: ;
            endcase
            ph_nxt = swdbg_next(f, ph_r);
            unique case (ph_nxt)
                PH_CMD: nb_nxt = BYTE_BITS;
                PH_ADR: nb_nxt = WORD_BITS;
                PH_WD: nb_nxt = (f.wd == 2'd2) ? WORD_BITS : BYTE_BITS;
                PH_SS: begin
                    nb_nxt = BYTE_BITS;
                    sh_nxt = {stat, 8'h00};
                end
                PH_RD: begin
                    nb_nxt = (f.rd == 2'd2) ? WORD_BITS : BYTE_BITS;
                    unique case (c)
                        CMD_STAT_FETCH: sh_nxt = {stat, 8'h00};
                        CMD_MATCH_FETCH: sh_nxt = bkpt_r;
                        CMD_ACC_FETCH: sh_nxt = {CPU_REGS.acc, 8'h00};
                        CMD_FLAGS_FETCH: sh_nxt = {CPU_REGS.flags, 8'h00};
                        CMD_PC_FETCH: sh_nxt = CPU_REGS.pc;
                        CMD_INDEX_FETCH: sh_nxt = CPU_REGS.ix;
                        CMD_STACK_PTR_FETCH: sh_nxt = CPU_REGS.sp;
                        default: sh_nxt = {rd_r, 8'h00};
                    endcase
                end
                PH_DLY: begin
                    dc_nxt = 5'h00;
                    if (e) begin
                        unique case (c)
                            CMD_BACKGROUND: halt_nxt = ctl_r[PERMIT_BIT];
                            CMD_ACK_ON: ack_nxt = 1'b1;
                            CMD_ACK_OFF: ack_nxt = 1'b0;
                            CMD_RESUME, CMD_RESUME_TAGGED: res_nxt = 1'b1;
                            CMD_SINGLE_STEP: stp_nxt = 1'b1;
                            CMD_MEM_FETCH, CMD_MEM_FETCH_FLAGS: begin
                                mem_nxt = '{req: 1'b1, we: 1'b0, addr: av, wdata: mem_r.wdata};
                                last_nxt = av;
                                rdv_nxt = 1'b1;
                            end
                            CMD_MEM_STORE, CMD_MEM_STORE_FLAGS: begin
                                mem_nxt = '{req: 1'b1, we: 1'b1, addr: av, wdata: sh_r[7:0]};
                            end
                            CMD_ACC_STORE: rw_nxt = '{we: 1'b1, sel: RS_ACC, data: wv};
                            CMD_FLAGS_STORE: rw_nxt = '{we: 1'b1, sel: RS_FLAGS, data: wv};
                            CMD_PC_STORE: rw_nxt = '{we: 1'b1, sel: RS_PC, data: wv};
                            CMD_INDEX_STORE: rw_nxt = '{we: 1'b1, sel: RS_IX, data: wv};
                            CMD_STACK_PTR_STORE: rw_nxt = '{we: 1'b1, sel: RS_SP, data: wv};
                            CMD_INDEX_STEP_FETCH, CMD_INDEX_STEP_FETCH_FLAGS: begin
                                rw_nxt = '{we: 1'b1, sel: RS_IX, data: ix1};
                                mem_nxt = '{req: 1'b1, we: 1'b0, addr: ix1, wdata: mem_r.wdata};
                                rdv_nxt = 1'b1;
                            end
                            CMD_INDEX_STEP_STORE, CMD_INDEX_STEP_STORE_FLAGS: begin
                                rw_nxt = '{we: 1'b1, sel: RS_IX, data: ix1};
                                mem_nxt = '{req: 1'b1, we: 1'b1, addr: ix1, wdata: sh_r[7:0]};
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end

        if (abort) begin
            ph_nxt = PH_CMD;
            nb_nxt = BYTE_BITS;
        end

        // Drive only inside a target-to-host bit or the sync reply; else leave to pullup
        if (ln_nxt == LN_BIT && tx) begin
            if (!sh_r[15] && cyc_nxt <= LOW_ZERO_CYC) begin
                oen_nxt = 1'b0;
                o_nxt = 1'b0;
            end else if (cyc_nxt == (sh_r[15] ? PU_ONE_CYC : LOW_ZERO_CYC + 9'h001)) begin
                oen_nxt = 1'b0;
            end
        end
        if (ln_nxt == LN_SYNC_LO) begin
            oen_nxt = 1'b0;
            o_nxt = 1'b0;
        end
        if (ln_nxt == LN_SYNC_PU) begin
            oen_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ln_r <= LN_WAIT;
            ph_r <= PH_CMD;
            fmt_r <= '0;
            mem_r <= '0;
            rw_r <= '{we: 1'b0, sel: RS_ACC, data: 16'h0000};
            cyc_r <= 9'h000;
            tmo_r <= 10'h000;
            nb_r <= BYTE_BITS;
            dc_r <= 5'h00;
            sh_r <= 16'h0000;
            adr_r <= 16'h0000;
            last_r <= 16'h0000;
            bkpt_r <= 16'h0000;
            cmd_r <= 8'h00;
            rd_r <= 8'h00;
            ctl_r <= CTL_RST;
            din_q_r <= 1'b1;
            hlt_q_r <= 1'b0;
            exe_r <= 1'b0;
            rdv_r <= 1'b0;
            ack_r <= 1'b0;
            halt_r <= 1'b0;
            res_r <= 1'b0;
            stp_r <= 1'b0;
            o_r <= 1'b1;
            oen_r <= 1'b1;
        end else begin
            ln_r <= ln_nxt;
            ph_r <= ph_nxt;
            fmt_r <= fmt_nxt;
            mem_r <= mem_nxt;
            rw_r <= rw_nxt;
            cyc_r <= cyc_nxt;
            tmo_r <= tmo_nxt;
            nb_r <= nb_nxt;
            dc_r <= dc_nxt;
            sh_r <= sh_nxt;
            adr_r <= adr_nxt;
            last_r <= last_nxt;
            bkpt_r <= bkpt_nxt;
            cmd_r <= cmd_nxt;
            rd_r <= rd_nxt;
            ctl_r <= ctl_nxt;
            din_q_r <= DBG_WIRE_I;
            hlt_q_r <= CPU_HALTED;
            exe_r <= exe_nxt;
            rdv_r <= rdv_nxt;
            ack_r <= ack_nxt;
            halt_r <= halt_nxt;
            res_r <= res_nxt;
            stp_r <= stp_nxt;
            o_r <= o_nxt;
            oen_r <= oen_nxt;
        end
    end

    assign DBG_WIRE_O = o_r;
    assign DBG_WIRE_OE_N = oen_r;
    assign REG_WR = rw_r;
    assign HALT_REQ = halt_r;
    assign RESUME = res_r;
    assign STEP = stp_r;
    assign MEM = mem_r;
    // Port copy of the halted bit lags one cycle so the port comes from a flop
    assign STATUS_CTL = {ctl_r[PERMIT_BIT], hlt_q_r, ctl_r[5:0]};
    assign BKPT_MATCH = bkpt_r;
    assign ACK_EN = ack_r;

    AST_SYNC_WAIT: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ln_r == LN_SYNC_DLY && $past(ln_r) == LN_SYNC_HI) |-> ##16 (ln_r == LN_SYNC_LO))
        else $error("sync reply did not wait 16 cycles");
    AST_SYNC_LOW: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ln_r == LN_SYNC_LO && $past(ln_r) != LN_SYNC_LO)
            |-> ##128 (ln_r == LN_SYNC_PU && !DBG_WIRE_OE_N && DBG_WIRE_O) ##1 DBG_WIRE_OE_N)
        else $error("sync low pulse not 128 cycles then one-cycle pulse");
    AST_SYNC_DRIVE: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ln_r == LN_SYNC_LO) |-> (!DBG_WIRE_OE_N && !DBG_WIRE_O))
        else $error("sync low not driven");
    AST_RX_SAMPLE: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ln_r == LN_WAIT && din_q_r && !DBG_WIRE_I && ph_r == PH_ADR)
            |-> ##11 (sh_r[15:1] == $past(sh_r[14:0], 11) && sh_r[0] == $past(DBG_WIRE_I)))
        else $error("host bit not sampled ten cycles after the edge");
    AST_TX_BIT: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ln_r == LN_BIT && (ph_r == PH_SS || ph_r == PH_RD) && cyc_r == PU_ONE_CYC)
            |-> (!DBG_WIRE_OE_N && DBG_WIRE_O == sh_r[15]))
        else $error("target bit drive wrong at cycle seven");
    AST_TIMEOUT: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ln_r == LN_WAIT && !(din_q_r && !DBG_WIRE_I) && tmo_r == TMO_CYC - 10'h001
            && (ph_r != PH_CMD || nb_r != BYTE_BITS)) |=> (ph_r == PH_CMD && nb_r == BYTE_BITS))
        else $error("command not aborted on timeout");
    AST_DELAY: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ph_r == PH_DLY && $past(ph_r) != PH_DLY) |-> ##15 (ph_r == PH_DLY) ##1 (ph_r != PH_DLY))
        else $error("delay slot not 16 cycles");
    AST_PERMIT: assert property (@(posedge CLK) disable iff (SYS_RST)
        HALT_REQ |-> ($past(ctl_r[PERMIT_BIT]) && $past(cmd_nxt) == CMD_BACKGROUND))
        else $error("background entered without permit");
    AST_HALTED_ONLY: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RESUME || STEP || REG_WR.we) |-> $past(CPU_HALTED))
        else $error("CPU command acted while running");
endmodule : swdbg_core

// ---- rtl/swdbg_pkg.sv ----
// Constants and types shared by the single-wire debug command decoder
package swdbg_pkg;
    // Timing in debug clock cycles (bit-cell values counted from the perceived falling edge), then field bit counts
    localparam logic [8:0] RX_SAMPLE_CYC = 9'h00a;
    localparam logic [8:0] PU_ONE_CYC = 9'h007;
    localparam logic [8:0] LOW_ZERO_CYC = 9'h00d;
    localparam logic [8:0] BIT_MIN_CYC = 9'h00f;
    localparam logic [8:0] SYNC_DET_CYC = 9'h040;
    localparam logic [8:0] SYNC_WAIT_CYC = 9'h010;
    localparam logic [8:0] SYNC_LOW_CYC = 9'h080;
    localparam logic [4:0] DLY_CYC = 5'h10;
    localparam logic [9:0] TMO_CYC = 10'h200;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] WORD_BITS = 5'h10;
    // Status/control byte
    localparam int PERMIT_BIT = 7;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] CTL_WR_MASK = 8'hbf;
    localparam logic [7:0] CTL_HALT_MASK = 8'h3f;
    // Command codes
    localparam logic [7:0] CMD_ACK_ON = 8'hd5;
    localparam logic [7:0] CMD_ACK_OFF = 8'hd6;
    localparam logic [7:0] CMD_BACKGROUND = 8'h90;
    localparam logic [7:0] CMD_STAT_FETCH = 8'he4;
    localparam logic [7:0] CMD_CTRL_STORE = 8'hc4;
    localparam logic [7:0] CMD_MEM_FETCH = 8'he0;
    localparam logic [7:0] CMD_MEM_FETCH_FLAGS = 8'he1;
    localparam logic [7:0] CMD_LAST_FETCH_FLAGS = 8'he8;
    localparam logic [7:0] CMD_MEM_STORE = 8'hc0;
    localparam logic [7:0] CMD_MEM_STORE_FLAGS = 8'hc1;
    localparam logic [7:0] CMD_MATCH_FETCH = 8'he2;
    localparam logic [7:0] CMD_MATCH_STORE = 8'hc2;
    localparam logic [7:0] CMD_RESUME = 8'h08;
    localparam logic [7:0] CMD_SINGLE_STEP = 8'h10;
    localparam logic [7:0] CMD_RESUME_TAGGED = 8'h18;
    localparam logic [7:0] CMD_ACC_FETCH = 8'h68;
    localparam logic [7:0] CMD_FLAGS_FETCH = 8'h69;
    localparam logic [7:0] CMD_PC_FETCH = 8'h6b;
    localparam logic [7:0] CMD_INDEX_FETCH = 8'h6c;
    localparam logic [7:0] CMD_STACK_PTR_FETCH = 8'h6f;
    localparam logic [7:0] CMD_INDEX_STEP_FETCH = 8'h70;
    localparam logic [7:0] CMD_INDEX_STEP_FETCH_FLAGS = 8'h71;
    localparam logic [7:0] CMD_ACC_STORE = 8'h48;
    localparam logic [7:0] CMD_FLAGS_STORE = 8'h49;
    localparam logic [7:0] CMD_PC_STORE = 8'h4b;
    localparam logic [7:0] CMD_INDEX_STORE = 8'h4c;
    localparam logic [7:0] CMD_STACK_PTR_STORE = 8'h4f;
    localparam logic [7:0] CMD_INDEX_STEP_STORE = 8'h50;
    localparam logic [7:0] CMD_INDEX_STEP_STORE_FLAGS = 8'h51;

    typedef enum logic [2:0] {PH_CMD, PH_ADR, PH_WD, PH_DLY, PH_SS, PH_RD} swdbg_ph_t;
    typedef enum logic [2:0] {
        LN_WAIT, LN_BIT, LN_SYNC_HI, LN_SYNC_DLY, LN_SYNC_LO, LN_SYNC_PU
    } swdbg_ln_t;
    typedef enum logic [2:0] {RS_ACC, RS_FLAGS, RS_PC, RS_IX, RS_SP} swdbg_rsel_t;
    // Field layout of a command: wd/rd are 0 none, 1 byte, 2 word
    typedef struct packed {
        logic ok;
        logic abm;
        logic adr;
        logic [1:0] wd;
        logic dly;
        logic ss;
        logic [1:0] rd;
    } swdbg_fmt_t;
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [15:0] pc;
        logic [15:0] ix;
        logic [15:0] sp;
    } swdbg_cpu_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } swdbg_mem_t;
    typedef struct packed {
        logic we;
        swdbg_rsel_t sel;
        logic [15:0] data;
    } swdbg_regwr_t;
endpackage : swdbg_pkg

// ---- verif/swdbg_pod.sv ----
// Debug pod model: starts every bit, sends and receives fields, times the sync reply
`timescale 1ns/1ps
module swdbg_pod (
    // Clock
    input wire logic clk,
    // Debug wire
    input wire logic wire_lvl,
    output logic host_low
);
    initial host_low = 1'b0;

    // Each bit opens with a host falling edge; fields go MSB first
    task automatic put(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk) host_low <= 1'b1;
            repeat (v[i] ? 4 : 13) @(posedge clk);
            host_low <= 1'b0;
            repeat (v[i] ? 14 : 5) @(posedge clk);
        end
    endtask : put

    // Release before the target's speedup pulse, sample near mid-bit
    task automatic get(output logic [15:0] v, input int n);
        v = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk) host_low <= 1'b1;
            repeat (2) @(posedge clk);
            host_low <= 1'b0;
            repeat (8) @(posedge clk);
            #1 v[i] = wire_lvl;
            repeat (9) @(posedge clk);
        end
    endtask : get

    // Long low request, then count the low cycles of the reply
    task automatic sync(output int lo);
        @(posedge clk) host_low <= 1'b1;
        repeat (80) @(posedge clk);
        host_low <= 1'b0;
        lo = 0;
        repeat (300) begin
            @(posedge clk);
            #1 if (!wire_lvl) lo++;
        end
    endtask : sync
endmodule : swdbg_pod

// ---- verif/swdbg_core_bench.sv ----
// Bench for the debug command decoder with pod, memory and CPU models
`timescale 1ns/1ps
module swdbg_core_bench;
    import swdbg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic halted = 1'b0;
    swdbg_cpu_t cpu = '0;
    swdbg_regwr_t regwr;
    swdbg_mem_t mem;
    logic halt_req, resume, step, wo, woe_n, host_low, wire_lvl, ack_en;
    logic [7:0] mem_rdata, status;
    logic [15:0] bkpt;
    logic [7:0] ram [0:65535];
    int n_step = 0;
    int bad_count = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;
    // Pull-up wins when nobody drives
    assign wire_lvl = !woe_n ? wo : !host_low;
    assign mem_rdata = ram[mem.addr];

    swdbg_core DUT (.CLK(clk), .SYS_RST(rst), .DBG_WIRE_I(wire_lvl), .DBG_WIRE_O(wo),
        .DBG_WIRE_OE_N(woe_n), .CPU_HALTED(halted), .CPU_REGS(cpu), .REG_WR(regwr),
        .HALT_REQ(halt_req), .RESUME(resume), .STEP(step), .MEM_RDATA(mem_rdata),
        .MEM(mem), .STATUS_CTL(status), .BKPT_MATCH(bkpt), .ACK_EN(ack_en));
    swdbg_pod pod (.clk(clk), .wire_lvl(wire_lvl), .host_low(host_low));

    // Memory and CPU stand-ins
    always @(posedge clk) begin
        if (mem.req && mem.we) ram[mem.addr] <= mem.wdata;
        if (halt_req) halted <= 1'b1;
        if (resume) halted <= 1'b0;
        if (step) n_step++;
        if (regwr.we) begin
            case (regwr.sel)
                RS_ACC: cpu.acc <= regwr.data[7:0];
                RS_FLAGS: cpu.flags <= regwr.data[7:0];
                RS_PC: cpu.pc <= regwr.data;
                RS_IX: cpu.ix <= regwr.data;
                default: cpu.sp <= regwr.data;
            endcase
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    task automatic cmd(input logic [7:0] c);
        pod.put({8'h00, c}, 8);
    endtask : cmd

    // Host keeps at least the 16-cycle slot
    task automatic dly;
        repeat (20) @(posedge clk);
    endtask : dly

    task automatic t_sync;
        int lo;
        pod.put(16'h000e, 4);
        pod.sync(lo);
        chk("sync low", lo[15:0], 16'h0080);
    endtask : t_sync

    task automatic t_ctl;
        logic [15:0] v;
        cmd(CMD_BACKGROUND);
        dly();
        chk("halt denied", {15'h0, halted}, 16'h0000);
        cmd(CMD_CTRL_STORE);
        pod.put(16'h00e5, 8);
        chk("ctl port", {8'h00, status}, 16'h00a5);
        cmd(CMD_BACKGROUND);
        dly();
        chk("halted", {15'h0, halted}, 16'h0001);
        // Permit bit must survive a clear while halted
        cmd(CMD_CTRL_STORE);
        pod.put(16'h0000, 8);
        cmd(CMD_STAT_FETCH);
        pod.get(v, 8);
        chk("status", v, 16'h00c0);
        cmd(CMD_MATCH_STORE);
        pod.put(16'h1234, 16);
        chk("match port", bkpt, 16'h1234);
        cmd(CMD_MATCH_FETCH);
        pod.get(v, 16);
        chk("match read", v, 16'h1234);
        cmd(CMD_ACK_ON);
        dly();
        chk("ack on", {15'h0, ack_en}, 16'h0001);
        cmd(CMD_ACK_OFF);
        dly();
        chk("ack off", {15'h0, ack_en}, 16'h0000);
    endtask : t_ctl

    task automatic t_mem;
        logic [15:0] v;
        cmd(CMD_MEM_STORE);
        pod.put(16'h0102, 16);
        pod.put(16'h005a, 8);
        dly();
        chk("mem wr", {8'h00, ram[16'h0102]}, 16'h005a);
        cmd(CMD_MEM_STORE_FLAGS);
        pod.put(16'h0103, 16);
        pod.put(16'h00c3, 8);
        dly();
        pod.get(v, 8);
        chk("wr status", v, 16'h00c0);
        cmd(CMD_MEM_FETCH);
        pod.put(16'h0102, 16);
        dly();
        pod.get(v, 8);
        chk("mem rd", v, 16'h005a);
        for (int k = 0; k < 2; k++) begin
            cmd(k == 0 ? CMD_MEM_FETCH_FLAGS : CMD_LAST_FETCH_FLAGS);
            if (k == 0) pod.put(16'h0103, 16);
            if (k == 0) dly();
            pod.get(v, 8);
            chk("rd status", v, 16'h00c0);
            pod.get(v, 8);
            chk("rd data", v, 16'h00c3);
        end
    endtask : t_mem

    task automatic t_cpu;
        logic [7:0] st [5] = '{CMD_ACC_STORE, CMD_FLAGS_STORE, CMD_PC_STORE,
            CMD_INDEX_STORE, CMD_STACK_PTR_STORE};
        logic [15:0] v, w;
        int n;
        for (int i = 0; i < 5; i++) begin
            n = (i < 2) ? 8 : 16;
            w = (i < 2) ? 16'h00a5 + 16'(i) : 16'h8e40 + 16'(i);
            cmd(st[i]);
            pod.put(w, n);
            dly();
            // Each fetch code sits 0x20 above its store code
            cmd(st[i] + 8'h20);
            dly();
            pod.get(v, n);
            chk("cpu reg", v, w);
        end
        cmd(CMD_INDEX_STORE);
        pod.put(16'h01ff, 16);
        dly();
        cmd(CMD_INDEX_STEP_STORE);
        pod.put(16'h0077, 8);
        dly();
        chk("step wr", {8'h00, ram[16'h0200]}, 16'h0077);
        chk("index", cpu.ix, 16'h0200);
        cmd(CMD_INDEX_STORE);
        pod.put(16'h01ff, 16);
        dly();
        cmd(CMD_INDEX_STEP_FETCH_FLAGS);
        dly();
        pod.get(v, 8);
        chk("step status", v, 16'h00c0);
        pod.get(v, 8);
        chk("step rd", v, 16'h0077);
        cmd(CMD_INDEX_STEP_STORE_FLAGS);
        pod.put(16'h0066, 8);
        dly();
        pod.get(v, 8);
        chk("step wr status", v, 16'h00c0);
        cmd(CMD_INDEX_STORE);
        pod.put(16'h0200, 16);
        dly();
        cmd(CMD_INDEX_STEP_FETCH);
        dly();
        pod.get(v, 8);
        chk("step rd plain", v, 16'h0066);
    endtask : t_cpu

    task automatic t_run;
        logic [15:0] v;
        cmd(CMD_SINGLE_STEP);
        dly();
        chk("steps", 16'(n_step), 16'h0001);
        chk("still halted", {15'h0, halted}, 16'h0001);
        cmd(CMD_RESUME_TAGGED);
        dly();
        chk("tagged run", {15'h0, halted}, 16'h0000);
        cmd(CMD_BACKGROUND);
        dly();
        cmd(CMD_RESUME);
        dly();
        chk("running", {15'h0, halted}, 16'h0000);
        cmd(CMD_ACC_STORE);
        pod.put(16'h003c, 8);
        dly();
        chk("acc kept", {8'h00, cpu.acc}, 16'h00a5);
        // Partial code, then a long silence must drop it
        pod.put(16'h0003, 2);
        repeat (600) @(posedge clk);
        cmd(CMD_STAT_FETCH);
        pod.get(v, 8);
        chk("status run", v, 16'h0080);
    endtask : t_run

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_sync();
        t_ctl();
        t_mem();
        t_cpu();
        t_run();
        final_report();
    end
endmodule : swdbg_core_bench
